// ===== design/ata_power_params.svh
// Constants for the idle, standby-timer and geometry command block.
`ifndef ATA_POWER_PARAMS_SVH
`define ATA_POWER_PARAMS_SVH

// ****************************************************************
// Command codes
// ****************************************************************
`define CMD_IDLE_A          8'he3
`define CMD_IDLE_B          8'h97
`define CMD_IDLE_NOW_A      8'he1
`define CMD_IDLE_NOW_B      8'h95
`define CMD_GEOMETRY        8'h91

// ****************************************************************
// Register offsets
// ****************************************************************
`define REG_SECTOR_COUNT    4'h2
`define REG_DEVICE_HEAD     4'h6
`define REG_COMMAND         4'h7
`define REG_ERROR           4'h1
`define REG_STATUS          4'h8
`define REG_GEOMETRY        4'h9
`define REG_POWER           4'ha
`define REG_FEATURE_OPT     4'hb
`define REG_IRQ_STATUS      4'hc
`define REG_IRQ_MASK        4'hd

// ****************************************************************
// Field positions and values
// ****************************************************************
`define ERR_ABORT_BIT       2
`define ST_BUSY_BIT         7
`define ST_READY_BIT        6
`define ST_FAULT_BIT        5
`define ST_SEEK_DONE_BIT    4
`define ST_DATA_REQ_BIT     3
`define ST_ERROR_BIT        0
`define DEV_SELECT_BIT      4
`define OPT_KEEP_SETTINGS   8'h66
`define OPT_REVERT_DEFAULTS 8'hcc
`define TIMEOUT_RESERVED    8'hfe
`define TIMEOUT_LINEAR_MAX  8'hf0
`define TIMEOUT_HALFHR_MAX  8'hfb
`define TIMEOUT_21_MIN      8'hfc
`define TIMEOUT_8_HOUR      8'hfd
`define TIMEOUT_21M15S      8'hff
`define IRQ_DONE_BIT        0
`define IRQ_ABORT_BIT       1
`define IRQ_STANDBY_BIT     2

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_HZ              25000000
`define TICK_SEC            1
`define TICK_CYCLES         (`CLK_HZ * `TICK_SEC)
`define LINEAR_STEP_SEC     5
`define HALF_HOUR_SEC       1800
`define SEC_21_MIN          1260
`define SEC_8_HOUR          28800
`define SEC_21M15S          1275
`define SPINUP_CYCLES       16'h0100
`define DEFAULT_SPT         8'h3f
`define DEFAULT_HEADS_M1    4'hf

`endif

// ===== design/ata_power_pkg.sv
// Types shared by the idle, standby-timer and geometry command block.
package ata_power_pkg;

  typedef enum logic [3:0] {
    SPIN_STANDBY = 4'h1,
    SPIN_UP      = 4'h2,
    SPIN_IDLE    = 4'h4,
    SPIN_DONE    = 4'h8
  } spin_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } host_bus_t;

  typedef struct packed {
    logic [7:0] sectors_per_track;
    logic [3:0] heads_minus_one;
  } geometry_t;

endpackage

// ===== design/timeout_decoder.sv
// Turns the standby timeout code into seconds and flags the reserved code.
`timescale 1ns/100ps
`default_nettype none
`include "ata_power_params.svh"

module timeout_decoder (
  // Timeout code
  input  wire logic [7:0]  code,
  // Decoded interval
  output logic      [15:0] seconds,
  output logic             enabled,
  output logic             reserved
);

  always_comb begin
    seconds  = 16'h0000;
    enabled  = (code != 8'h00);
    reserved = (code == `TIMEOUT_RESERVED);
    if (code <= `TIMEOUT_LINEAR_MAX) begin
      seconds = 16'(code) * 16'(`LINEAR_STEP_SEC);
    end else if (code <= `TIMEOUT_HALFHR_MAX) begin
      seconds = 16'(code - `TIMEOUT_LINEAR_MAX) * 16'(`HALF_HOUR_SEC);
    end else begin
      case (code)
        `TIMEOUT_21_MIN: seconds = 16'(`SEC_21_MIN);
        `TIMEOUT_8_HOUR: seconds = 16'(`SEC_8_HOUR);
        `TIMEOUT_21M15S: seconds = 16'(`SEC_21M15S);
        default:         seconds = 16'h0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== design/standby_timer.sv
// Seconds countdown that signals expiry of the standby interval.
`timescale 1ns/100ps
`default_nettype none
`include "ata_power_params.svh"

module standby_timer #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Control
  input  wire logic        load,
  input  wire logic        enable,
  input  wire logic [15:0] interval,
  // Result
  output logic             expired
);

  typedef struct packed {
    logic [31:0] prescale;
    logic [15:0] remaining;
    logic        running;
    logic        expired;
  } timer_state_t;

  timer_state_t cur;
  timer_state_t next_cur;

  always_comb begin
    next_cur         = cur;
    next_cur.expired = 1'b0;
    if (load) begin
      next_cur.prescale  = 32'h0;
      next_cur.remaining = interval;
      next_cur.running   = enable && (interval != 16'h0000);
    end else if (cur.running) begin
      if (cur.prescale == 32'(TICK_CYCLES - 1)) begin
        next_cur.prescale = 32'h0;
        if (cur.remaining <= 16'h0001) begin
          next_cur.running = 1'b0;
          next_cur.expired = 1'b1;
        end else begin
          next_cur.remaining = cur.remaining - 16'h0001;
        end
      end else begin
        next_cur.prescale = cur.prescale + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign expired = cur.expired;

endmodule
`default_nettype wire

// ===== design/ata_power_cmd.sv
// Command handler for idle, idle immediate and geometry setup commands.
// Contract
// - Idle command enters idle, loads countdown from sector count, starts it.
// - Entering idle spins up, unless spindle already spinning.
// - Timeout zero disables countdown; nonzero enables with encoded interval.
// - Codes 1-240 mean value times 5 s; 241-251 mean (value-240) half-hours.
// - 252 is 21 min, 253 is 8 h, 255 is 21 min 15 s, 254 aborts.
// - Enabled countdown expiring without host access moves device to standby.
// - Any host access before expiry reloads the full interval.
// - Idle immediate enters idle, spinning up only if not spinning.
// - Idle immediate leaves timeout value and enable untouched.
// - In idle the spindle runs and commands are serviced without spin-up delay.
// - Geometry command stores sectors per track and heads minus one, shown.
// - Geometry persists until new command, power off, or soft reset with revert.
// - Sectors per track zero means zero, never 256.
// - Heads minus one spans 0 to 15; stored as given.
`timescale 1ns/100ps
`default_nettype none
`include "ata_power_params.svh"

module ata_power_cmd #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Soft reset from the link
  input  wire logic       soft_reset,
  // Register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Spindle status
  input  wire logic       spindle_at_speed,
  output logic            spindle_run,
  // Identify geometry words
  output logic      [7:0] identify_sectors,
  output logic      [3:0] identify_heads_m1,
  // Interrupt
  output logic            irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]                 sector_count;
    logic [7:0]                 device_head;
    logic [7:0]                 feature_opt;
    logic [7:0]                 timeout_code;
    logic [7:0]                 error;
    logic [7:0]                 status;
    ata_power_pkg::geometry_t   geom;
    ata_power_pkg::spin_state_t spin;
    logic [15:0]                spin_count;
    logic [2:0]                 irq_status;
    logic [2:0]                 irq_mask;
    logic                       timer_load;
    logic [7:0]                 rdata;
    logic                       irq;
    logic                       spin_run;
  } cmd_state_t;

  cmd_state_t cur;
  cmd_state_t next_cur;

  logic [15:0] interval;
  logic        timer_on;
  logic        code_reserved;
  logic        expired;
  logic [7:0]  new_code;
  logic        is_cmd;
  logic        host_access;

  function automatic logic [7:0] done_status(input logic failed);
    logic [7:0] s;
    s = 8'h00;
    s[`ST_READY_BIT]     = 1'b1;
    s[`ST_SEEK_DONE_BIT] = 1'b1;
    s[`ST_ERROR_BIT]     = failed;
    return s;
  endfunction

  // The decoder watches the code being written so an abort is known at once.
  assign new_code = (is_cmd && (wdata == `CMD_IDLE_A || wdata == `CMD_IDLE_B))
                    ? cur.sector_count : cur.timeout_code;

  timeout_decoder u_decode (
    .code     (new_code),
    .seconds  (interval),
    .enabled  (timer_on),
    .reserved (code_reserved)
  );

  standby_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk      (clk),
    .rst_b    (rst_b),
    .load     (cur.timer_load),
    .enable   (timer_on),
    .interval (interval),
    .expired  (expired)
  );

  assign is_cmd      = wr && (addr == `REG_COMMAND) && cur.device_head[`DEV_SELECT_BIT] == 1'b0;
  assign host_access = wr || rd;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_cur            = cur;
    next_cur.timer_load = 1'b0;
    next_cur.rdata      = 8'h00;

    // Reads answer one cycle later.
    if (rd) begin
      case (addr)
        `REG_SECTOR_COUNT: next_cur.rdata = cur.sector_count;
        `REG_DEVICE_HEAD:  next_cur.rdata = cur.device_head;
        `REG_ERROR:        next_cur.rdata = cur.error;
        `REG_STATUS:       next_cur.rdata = cur.status;
        `REG_GEOMETRY:     next_cur.rdata = {cur.geom.heads_minus_one, 4'h0};
        `REG_POWER:        next_cur.rdata = {4'h0, cur.spin};
        `REG_FEATURE_OPT:  next_cur.rdata = cur.feature_opt;
        `REG_IRQ_STATUS:   next_cur.rdata = {5'h00, cur.irq_status};
        `REG_IRQ_MASK:     next_cur.rdata = {5'h00, cur.irq_mask};
        default:           next_cur.rdata = 8'h00;
      endcase
    end

    // Host activity restarts the countdown with the programmed interval.
    if (host_access && cur.timeout_code != 8'h00) begin
      next_cur.timer_load = 1'b1;
    end

    // Spindle sequencing.
    case (cur.spin)
      ata_power_pkg::SPIN_UP: begin
        if (spindle_at_speed || cur.spin_count == 16'h0000) begin
          next_cur.spin   = ata_power_pkg::SPIN_IDLE;
          next_cur.status = done_status(cur.error != 8'h00);
        end else begin
          next_cur.spin_count = cur.spin_count - 16'h0001;
        end
      end
      ata_power_pkg::SPIN_IDLE,
      ata_power_pkg::SPIN_DONE,
      ata_power_pkg::SPIN_STANDBY: begin
      end
      default: next_cur.spin = ata_power_pkg::SPIN_STANDBY;
    endcase

    if (expired && !host_access && cur.spin == ata_power_pkg::SPIN_IDLE) begin
      next_cur.spin = ata_power_pkg::SPIN_STANDBY;
      next_cur.irq_status[`IRQ_STANDBY_BIT] = 1'b1;
    end

    if (wr) begin
      case (addr)
        `REG_SECTOR_COUNT: next_cur.sector_count = wdata;
        `REG_DEVICE_HEAD:  next_cur.device_head  = wdata;
        `REG_FEATURE_OPT:  next_cur.feature_opt  = wdata;
        `REG_IRQ_MASK:     next_cur.irq_mask     = wdata[2:0];
        `REG_IRQ_STATUS:   next_cur.irq_status   = cur.irq_status & ~wdata[2:0];
        default: begin
        end
      endcase
    end

    if (is_cmd) begin
      next_cur.error = 8'h00;
      case (wdata)
        `CMD_IDLE_A, `CMD_IDLE_B: begin
          if (code_reserved) begin
            next_cur.error[`ERR_ABORT_BIT] = 1'b1;
            next_cur.status = done_status(1'b1);
            next_cur.irq_status[`IRQ_ABORT_BIT] = 1'b1;
          end else begin
            next_cur.timeout_code = cur.sector_count;
            next_cur.timer_load   = 1'b1;
          end
        end
        `CMD_IDLE_NOW_A, `CMD_IDLE_NOW_B: begin
          // Timeout code is left as is.
        end
        `CMD_GEOMETRY: begin
          next_cur.geom.sectors_per_track = cur.sector_count;
          next_cur.geom.heads_minus_one   = cur.device_head[3:0];
          next_cur.status = done_status(1'b0);
          next_cur.irq_status[`IRQ_DONE_BIT] = 1'b1;
        end
        default: begin
          next_cur.error[`ERR_ABORT_BIT] = 1'b1;
          next_cur.status = done_status(1'b1);
          next_cur.irq_status[`IRQ_ABORT_BIT] = 1'b1;
        end
      endcase
      if ((wdata == `CMD_IDLE_NOW_A || wdata == `CMD_IDLE_NOW_B) ||
          ((wdata == `CMD_IDLE_A || wdata == `CMD_IDLE_B) && !code_reserved)) begin
        next_cur.irq_status[`IRQ_DONE_BIT] = 1'b1;
        if (spindle_at_speed) begin
          next_cur.spin   = ata_power_pkg::SPIN_IDLE;
          next_cur.status = done_status(1'b0);
        end else begin
          next_cur.spin       = ata_power_pkg::SPIN_UP;
          next_cur.spin_count = `SPINUP_CYCLES;
          next_cur.status     = 8'h00;
          next_cur.status[`ST_BUSY_BIT] = 1'b1;
        end
      end
    end

    // Revert to power-on geometry only when the option says so.
    if (soft_reset && cur.feature_opt == `OPT_REVERT_DEFAULTS) begin
      next_cur.geom.sectors_per_track = `DEFAULT_SPT;
      next_cur.geom.heads_minus_one   = `DEFAULT_HEADS_M1;
    end

    next_cur.irq      = |(next_cur.irq_status & next_cur.irq_mask);
    next_cur.spin_run = (next_cur.spin != ata_power_pkg::SPIN_STANDBY);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cur                         <= '0;
      cur.spin                    <= ata_power_pkg::SPIN_STANDBY;
      cur.status                  <= 8'h50;
      cur.feature_opt             <= `OPT_KEEP_SETTINGS;
      cur.geom.sectors_per_track  <= `DEFAULT_SPT;
      cur.geom.heads_minus_one    <= `DEFAULT_HEADS_M1;
    end else begin
      cur <= next_cur;
    end
  end

  assign rdata             = cur.rdata;
  assign irq               = cur.irq;
  assign spindle_run       = cur.spin_run;
  assign identify_sectors  = cur.geom.sectors_per_track;
  assign identify_heads_m1 = cur.geom.heads_minus_one;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_geom_store;
    @(posedge clk) disable iff (!rst_b)
      (is_cmd && wdata == `CMD_GEOMETRY && !soft_reset) |=>
        identify_sectors == $past(cur.sector_count) && identify_heads_m1 == $past(cur.device_head[3:0]);
  endproperty
  a_geom_store: assert property (p_geom_store) else $error("Geometry not stored.");

  property p_abort_reserved;
    @(posedge clk) disable iff (!rst_b)
      (is_cmd && wdata == `CMD_IDLE_A && cur.sector_count == `TIMEOUT_RESERVED) |=>
        cur.error == 8'h04 && cur.status[`ST_ERROR_BIT];
  endproperty
  a_abort_reserved: assert property (p_abort_reserved) else $error("Reserved code not aborted.");

  property p_abort_only;
    @(posedge clk) disable iff (!rst_b)
      cur.error != 8'h00 |-> cur.error == 8'h04 && cur.status[`ST_ERROR_BIT];
  endproperty
  a_abort_only: assert property (p_abort_only) else $error("Error bits other than abort.");

  property p_idle_now_keeps;
    @(posedge clk) disable iff (!rst_b)
      (is_cmd && wdata == `CMD_IDLE_NOW_A) |=> $stable(cur.timeout_code);
  endproperty
  a_idle_now_keeps: assert property (p_idle_now_keeps) else $error("Timeout changed.");

  property p_idle_load;
    @(posedge clk) disable iff (!rst_b)
      (is_cmd && wdata == `CMD_IDLE_B && !code_reserved) |=> cur.timeout_code == $past(cur.sector_count) ##0 cur.timer_load;
  endproperty
  a_idle_load: assert property (p_idle_load) else $error("Idle did not load timer.");

  property p_fast_idle;
    @(posedge clk) disable iff (!rst_b)
      (is_cmd && wdata == `CMD_IDLE_NOW_B && spindle_at_speed) |=> cur.spin == ata_power_pkg::SPIN_IDLE;
  endproperty
  a_fast_idle: assert property (p_fast_idle) else $error("Spin-up not skipped.");

  property p_done_status;
    @(posedge clk) disable iff (!rst_b)
      cur.spin == ata_power_pkg::SPIN_IDLE |-> !cur.status[`ST_BUSY_BIT] && !cur.status[`ST_FAULT_BIT]
        && !cur.status[`ST_DATA_REQ_BIT];
  endproperty
  a_done_status: assert property (p_done_status) else $error("Bad completion status.");

  property p_reload;
    @(posedge clk) disable iff (!rst_b)
      (host_access && cur.timeout_code != 8'h00) |=> cur.timer_load;
  endproperty
  a_reload: assert property (p_reload) else $error("Access did not reload timer.");

  property p_standby;
    @(posedge clk) disable iff (!rst_b)
      (expired && !host_access && cur.spin == ata_power_pkg::SPIN_IDLE && !is_cmd) |=>
        cur.spin == ata_power_pkg::SPIN_STANDBY;
  endproperty
  a_standby: assert property (p_standby) else $error("No standby on expiry.");

  property p_zero_quiet;
    @(posedge clk) disable iff (!rst_b)
      (cur.timeout_code == 8'h00 && !cur.timer_load) |-> !expired;
  endproperty
  a_zero_quiet: assert property (p_zero_quiet) else $error("Countdown ran with zero timeout.");

  property p_now_enters;
    @(posedge clk) disable iff (!rst_b)
      (is_cmd && (wdata == `CMD_IDLE_NOW_A || wdata == `CMD_IDLE_NOW_B)) |=>
        cur.spin_run && (cur.spin == ata_power_pkg::SPIN_IDLE || cur.spin == ata_power_pkg::SPIN_UP);
  endproperty
  a_now_enters: assert property (p_now_enters) else $error("Idle immediate did not enter idle.");

  property p_spin_busy;
    @(posedge clk) disable iff (!rst_b)
      (is_cmd && !spindle_at_speed && (wdata == `CMD_IDLE_NOW_A || (wdata == `CMD_IDLE_A && !code_reserved))) |=>
        cur.spin == ata_power_pkg::SPIN_UP && cur.status[`ST_BUSY_BIT];
  endproperty
  a_spin_busy: assert property (p_spin_busy) else $error("Stopped spindle not spun up.");

  property p_spin_limit;
    @(posedge clk) disable iff (!rst_b)
      (cur.spin == ata_power_pkg::SPIN_UP && cur.spin_count == 16'h0000 && !is_cmd) |=>
        cur.spin == ata_power_pkg::SPIN_IDLE && cur.status[`ST_READY_BIT] && !cur.status[`ST_BUSY_BIT];
  endproperty
  a_spin_limit: assert property (p_spin_limit) else $error("Spin-up did not complete at its limit.");

  property p_revert;
    @(posedge clk) disable iff (!rst_b)
      (soft_reset && cur.feature_opt == `OPT_REVERT_DEFAULTS) |=>
        identify_sectors == `DEFAULT_SPT && identify_heads_m1 == `DEFAULT_HEADS_M1;
  endproperty
  a_revert: assert property (p_revert) else $error("Geometry not reverted on soft reset.");

  property p_geom_zero;
    @(posedge clk) disable iff (!rst_b)
      (is_cmd && wdata == `CMD_GEOMETRY && cur.sector_count == 8'h00 && !soft_reset) |=> identify_sectors == 8'h00;
  endproperty
  a_geom_zero: assert property (p_geom_zero) else $error("Zero sectors per track not kept.");

endmodule
`default_nettype wire

// ===== test/spindle_model.sv
// Behavioural spindle motor that reaches speed some cycles after it is told to run.
`timescale 1ns/100ps
`default_nettype none

module spindle_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Motor control
  input  wire logic run,
  input  wire logic slow,
  output logic      at_speed
);
  int unsigned cnt;

  // A slow motor outlasts the device's spin-up limit, so that limit gets exercised.
  always_ff @(posedge clk) begin
    if (!rst_b || !run) begin
      cnt      <= 0;
      at_speed <= 1'b0;
    end else if (cnt < (slow ? 300 : 20)) begin
      cnt <= cnt + 1;
    end else begin
      at_speed <= 1'b1;
    end
  end
endmodule

`default_nettype wire

// ===== test/ata_idle_power_and_geometry_cmds_tb_top.sv
// Self-checking testbench of the idle, standby-timer and geometry command block.
`timescale 1ns/100ps
`default_nettype none
`include "ata_power_params.svh"

module ata_idle_power_and_geometry_cmds_tb_top;
  localparam int TICK = 10;
  logic        clk        = 1'b0;
  logic        rst_b      = 1'b0;
  logic        soft_reset = 1'b0;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic        slow       = 1'b0;
  logic        rd_seen    = 1'b0;
  logic [3:0]  addr       = 4'h0;
  logic [7:0]  wdata      = 8'h00;
  logic [31:0] rng        = 32'h749b;
  logic [7:0]  rdata;
  logic [7:0]  id_spt;
  logic [3:0]  id_h;
  logic        spin;
  logic        at_speed;
  logic        irq;
  logic [7:0]  spt;
  logic [3:0]  hd;
  logic [15:0] note;
  logic [15:0] expq[$];
  int          bad_count = 0;
  int          compares  = 0;
  logic [7:0]  tc_cmd[5] = '{`CMD_IDLE_A, `CMD_IDLE_B, `CMD_IDLE_A, `CMD_IDLE_A, `CMD_IDLE_B};
  logic [7:0]  tc_code[5] = '{8'h01, 8'hf0, 8'hf1, 8'hfc, 8'hff};
  int          tc_sec[5] = '{5, 240 * 5, 30 * 60, 21 * 60, 21 * 60 + 15};
  logic [7:0]  ab_cmd[3] = '{`CMD_IDLE_A, `CMD_IDLE_B, 8'h20};

  ata_power_cmd #(.TICK_CYCLES(TICK)) DUT (
    .clk(clk), .rst_b(rst_b), .soft_reset(soft_reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .spindle_at_speed(at_speed), .spindle_run(spin), .identify_sectors(id_spt),
    .identify_heads_m1(id_h), .irq(irq)
  );

  spindle_model motor (.clk(clk), .rst_b(rst_b), .run(spin), .slow(slow), .at_speed(at_speed));

  always #20 clk = ~clk;

  // ****************************************************************
  // Checking
  // ****************************************************************
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe, so the note is taken one edge later.
  always @(posedge clk) begin
    if (rd_seen) begin
      note = expq.pop_front();
      check("rdata", rdata & note[15:8], note[7:0]);
    end
    rd_seen <= rd;
  end

  initial begin
    repeat (80000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] x);
    expq.push_back({m, x});
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // Parameters go in before the command code, device select bit taken from dh as given.
  task automatic cmd(input logic [7:0] sc, input logic [7:0] dh, input logic [7:0] c);
    wreg(`REG_SECTOR_COUNT, sc);
    wreg(`REG_DEVICE_HEAD, dh);
    wreg(`REG_COMMAND, c);
  endtask

  task automatic pulse_soft_reset();
    @(posedge clk);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    idle(1);
  endtask

  task automatic expire(input int secs);
    idle(secs * TICK - TICK - 6);
    check("spin_early", {7'h0, spin}, 8'h01);
    idle(2 * TICK + 12);
    check("spin_late", {7'h0, spin}, 8'h00);
    rreg(`REG_POWER, 8'h0f, 8'h01);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    idle(6);
    rst_b <= 1'b1;
    check("spt_rst", id_spt, `DEFAULT_SPT);
    check("heads_rst", {4'h0, id_h}, 8'h0f);
    rreg(`REG_STATUS, 8'hff, 8'h50);
    rreg(`REG_ERROR, 8'hff, 8'h00);
    rreg(`REG_IRQ_MASK, 8'hff, 8'h00);
    rreg(`REG_FEATURE_OPT, 8'hff, 8'h66);
    cmd(8'h00, 8'ha0, `CMD_IDLE_A);
    idle(1);
    check("spin_idle", {7'h0, spin}, 8'h01);
    rreg(`REG_STATUS, 8'h80, 8'h80);
    idle(300);
    check("spin_off", {7'h0, spin}, 8'h01);
    rreg(`REG_STATUS, 8'he9, 8'h40);
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      spt = (i == 0) ? 8'h00 : rng[7:0];
      hd  = (i == 1) ? 4'h0 : (i == 2) ? 4'hf : rng[11:8];
      cmd(spt, {4'ha, hd}, `CMD_GEOMETRY);
      rreg(`REG_STATUS, 8'he9, 8'h40);
      check("spt", id_spt, spt);
      check("heads", {4'h0, id_h}, {4'h0, hd});
      rreg(`REG_GEOMETRY, 8'hf0, {hd, 4'h0});
      rreg(`REG_ERROR, 8'hff, 8'h00);
    end
    cmd(spt + 8'h01, {4'hb, ~hd}, `CMD_GEOMETRY);
    pulse_soft_reset();
    check("spt_keep", id_spt, spt);
    check("heads_keep", {4'h0, id_h}, {4'h0, hd});
    wreg(`REG_FEATURE_OPT, `OPT_REVERT_DEFAULTS);
    pulse_soft_reset();
    check("spt_revert", id_spt, `DEFAULT_SPT);
    check("heads_revert", {4'h0, id_h}, 8'h0f);
    for (int i = 0; i < 3; i++) begin
      cmd(`TIMEOUT_RESERVED, 8'ha0, ab_cmd[i]);
      rreg(`REG_ERROR, 8'hff, 8'h04);
      rreg(`REG_STATUS, 8'he9, 8'h41);
      rreg(`REG_IRQ_STATUS, 8'h02, 8'h02);
      wreg(`REG_IRQ_STATUS, 8'h07);
    end
    cmd(8'h02, 8'ha0, `CMD_IDLE_B);
    for (int i = 0; i < 5; i++) begin
      idle(60);
      rreg(`REG_STATUS, 8'he9, 8'h40);
    end
    check("spin_reload", {7'h0, spin}, 8'h01);
    cmd(8'h01, 8'ha0, `CMD_IDLE_A);
    idle(20);
    cmd(8'h00, 8'ha0, `CMD_IDLE_NOW_B);
    expire(5);
    check("irq_masked", {7'h0, irq}, 8'h00);
    cmd(8'h00, 8'ha0, `CMD_IDLE_NOW_A);
    idle(1);
    check("spin_now", {7'h0, spin}, 8'h01);
    rreg(`REG_STATUS, 8'h80, 8'h80);
    idle(25);
    rreg(`REG_STATUS, 8'he9, 8'h40);
    rreg(`REG_POWER, 8'h0f, 8'h04);
    wreg(`REG_IRQ_MASK, 8'h04);
    for (int i = 0; i < 5; i++) begin
      cmd(tc_code[i], 8'ha0, tc_cmd[i]);
      expire(tc_sec[i]);
      check("irq_set", {7'h0, irq}, 8'h01);
      rreg(`REG_IRQ_STATUS, 8'h04, 8'h04);
      wreg(`REG_IRQ_STATUS, 8'h07);
      idle(2);
      check("irq_clr", {7'h0, irq}, 8'h00);
    end
    slow <= 1'b1;
    cmd(8'h00, 8'ha0, `CMD_IDLE_A);
    idle(200);
    rreg(`REG_STATUS, 8'h80, 8'h80);
    idle(80);
    rreg(`REG_STATUS, 8'he9, 8'h40);
    idle(4);
    check("notes_left", 8'(expq.size()), 8'h00);
    give_verdict();
  end
endmodule

`default_nettype wire
